// *** pwm16_pkg.sv ***
// constants and types for the cascaded sixteen-bit pwm generator
// Operation
// RL1 - two 8-bit counters form one 16-bit counter
// RL2 - count internal prescaled clock or external pin
// RL3 - duty match inverts flip-flop, counter keeps running
// RL4 - overflow inverts again, clears, raises period irq
// RL5 - external count levels last two machine cycles
// RL6 - flip-flop loads init bit, resets to zero
// RL7 - output pin is inverse of flip-flop
// RL8 - running: duty buffered until period irq
// RL9 - stopped: duty transferred right after write
// RL10 - software writes low byte then high byte
// RL11 - duty read returns active value until transfer
// RL12 - software sets port latch to one
// RL13 - software writes duty right after irq
// RL14 - stop holds pin; change init after stop
// RL15 - clear bit3 stops, then bit7 forces high
// RL16 - stop counter before entering stop mode
// RL17 - clock select list, divider bit, slow limits
// RL18 - start bit set begins counting and matching
// RL19 - count zero to all-ones, period 65536
package pwm16_pkg;
  // register byte offsets
  localparam logic [7:0] LOWER_CTRL_OFS = 8'h00;
  localparam logic [7:0] UPPER_CTRL_OFS = 8'h04;
  localparam logic [7:0] DUTY_LOW_OFS = 8'h08;
  localparam logic [7:0] DUTY_HIGH_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] SYS_CFG_OFS = 8'h14;
  // field positions
  localparam int SEL_LSB = 4;
  localparam int START_BIT = 3;
  localparam int INIT_BIT = 7;
  localparam int DIVSEL_BIT = 0;
  localparam int SLOW_BIT = 1;
  localparam int STAT_RUN_BIT = 16;
  localparam int STAT_FF_BIT = 17;
  // reset values, and the all-ones top of the counter
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // prescaler taps, as log2 of the divide ratio
  localparam int PRE_W = 11;
  localparam int DIV_A = 11;
  localparam int DIV_B = 7;
  localparam int DIV_C = 5;
  localparam int DIV_D = 3;
  localparam int LOW_DIV = 3;
  // counting clock choices
  typedef enum logic [2:0]
  {
    SRC_DIV_A = 3'b000,
    SRC_DIV_B = 3'b001,
    SRC_DIV_C = 3'b010,
    SRC_DIV_D = 3'b011,
    SRC_LOW = 3'b100,
    SRC_HALF = 3'b101,
    SRC_HIGH = 3'b110,
    SRC_EXT = 3'b111
  } src_sel_t;
endpackage : pwm16_pkg

// *** pwm16_gen.sv ***
// cascaded sixteen-bit pwm generator with apb register access
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pwm16_gen
(
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // clock and count sources, synchronous levels
  input wire logic LOW_CLK,
  input wire logic COUNT_IN,
  // pwm pin and period event
  output logic PWM_OUT_N,
  output logic PERIOD_IRQ
);
  import pwm16_pkg::*;

  // all-ones test on the low bits of the prescaler
  function automatic logic tap(input logic [PRE_W-1:0] p, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < PRE_W; i++)
      if (i < n)
        r = r & p[i];
    return r;
  endfunction : tap

  logic [7:0] lower_timer_ctrl_q, lower_timer_ctrl_d;
  logic [7:0] upper_timer_ctrl_q, upper_timer_ctrl_d;
  logic [1:0] sys_cfg_q, sys_cfg_d;
  logic [7:0] buf_low_q, buf_low_d;
  logic [7:0] buf_high_q, buf_high_d;
  logic [15:0] duty_q, duty_d;
  logic pend_q, pend_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic slverr_q, slverr_d;
  logic [15:0] cnt_q, cnt_d;
  logic ff_q, ff_d;
  logic out_n_q, out_n_d;
  logic irq_q, irq_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [LOW_DIV-1:0] lowdiv_q, lowdiv_d;
  logic low_prev_q, low_prev_d;
  logic ext_prev_q, ext_prev_d;

  logic done, wr, hit, run, run_new;
  logic low_tick, ext_tick, tick, ovf, match;
  src_sel_t sel;

  // transfer completes at the edge where pready is seen high
  assign done = PSEL & PENABLE & pready_q;
  assign wr = done & PWRITE;
  assign hit = (PADDR == LOWER_CTRL_OFS) | (PADDR == UPPER_CTRL_OFS) |
    (PADDR == DUTY_LOW_OFS) | (PADDR == DUTY_HIGH_OFS) |
    (PADDR == STATUS_OFS) | (PADDR == SYS_CFG_OFS);
  assign run = upper_timer_ctrl_q[START_BIT];
  assign run_new = upper_timer_ctrl_d[START_BIT];
  assign sel = src_sel_t'(lower_timer_ctrl_q[SEL_LSB +: 3]);

  // apb registers; one wait state so read data comes from a flop
  always_comb
  begin
    lower_timer_ctrl_d = lower_timer_ctrl_q;
    upper_timer_ctrl_d = upper_timer_ctrl_q;
    sys_cfg_d = sys_cfg_q;
    buf_low_d = buf_low_q;
    buf_high_d = buf_high_q;
    pready_d = PSEL & PENABLE & ~pready_q;
    slverr_d = PSEL & PENABLE & ~pready_q & ~hit;
    prdata_d = prdata_q;
    if (PSEL & PENABLE & ~pready_q & ~PWRITE)
    begin
      unique case (PADDR)
        LOWER_CTRL_OFS: prdata_d = {24'h000000, lower_timer_ctrl_q};
        UPPER_CTRL_OFS: prdata_d = {24'h000000, upper_timer_ctrl_q};
        // active value shows until the period transfer
        DUTY_LOW_OFS: prdata_d = {24'h000000, duty_q[7:0]}; // RL11
        DUTY_HIGH_OFS: prdata_d = {24'h000000, duty_q[15:8]}; // RL11
        STATUS_OFS: prdata_d = {14'h0, ff_q, run, cnt_q};
        SYS_CFG_OFS: prdata_d = {30'h0, sys_cfg_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
    if (wr)
    begin
      unique case (PADDR)
        LOWER_CTRL_OFS: lower_timer_ctrl_d = PWDATA[7:0];
        UPPER_CTRL_OFS: upper_timer_ctrl_d = PWDATA[7:0]; // RL18 RL15
        // low byte first, high byte completes the pair
        DUTY_LOW_OFS: buf_low_d = PWDATA[7:0]; // RL10
        DUTY_HIGH_OFS: buf_high_d = PWDATA[7:0]; // RL10
        SYS_CFG_OFS: sys_cfg_d = PWDATA[1:0];
        default: ;
      endcase
    end
  end

  // bus side registers, frozen with the rest while ce is low
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      lower_timer_ctrl_q <= CTRL_RST;
      upper_timer_ctrl_q <= CTRL_RST;
      sys_cfg_q <= 2'h0;
      buf_low_q <= DUTY_RST[7:0];
      buf_high_q <= DUTY_RST[15:8];
      pready_q <= 1'b0;
      slverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (CE)
    begin
      lower_timer_ctrl_q <= lower_timer_ctrl_d;
      upper_timer_ctrl_q <= upper_timer_ctrl_d;
      sys_cfg_q <= sys_cfg_d;
      buf_low_q <= buf_low_d;
      buf_high_q <= buf_high_d;
      pready_q <= pready_d;
      slverr_q <= slverr_d;
      prdata_q <= prdata_d;
    end
  end

  // clock select; slow mode blocks every high-clock choice
  always_comb
  begin
    low_tick = LOW_CLK & ~low_prev_q;
    ext_tick = ~COUNT_IN & ext_prev_q; // RL2
    unique case (sel)
      SRC_DIV_A: tick = sys_cfg_q[DIVSEL_BIT] ?
        (low_tick & (&lowdiv_q)) : // RL17
        (~sys_cfg_q[SLOW_BIT] & tap(pre_q, DIV_A));
      SRC_DIV_B: tick = ~sys_cfg_q[SLOW_BIT] & tap(pre_q, DIV_B); // RL17
      SRC_DIV_C: tick = ~sys_cfg_q[SLOW_BIT] & tap(pre_q, DIV_C);
      SRC_DIV_D: tick = ~sys_cfg_q[SLOW_BIT] & tap(pre_q, DIV_D);
      SRC_LOW: tick = low_tick; // RL17
      SRC_HALF: tick = ~sys_cfg_q[SLOW_BIT] & pre_q[0];
      SRC_HIGH: tick = ~sys_cfg_q[SLOW_BIT]; // RL17
      SRC_EXT: tick = ext_tick; // RL2
    endcase
    match = cnt_q == duty_q;
    ovf = cnt_q == CNT_MAX; // RL19
  end

  // cascaded counter, output flip-flop and duty transfer
  always_comb
  begin
    pre_d = pre_q + 1'b1;
    low_prev_d = LOW_CLK;
    ext_prev_d = COUNT_IN;
    lowdiv_d = lowdiv_q + {{(LOW_DIV-1){1'b0}}, low_tick};
    cnt_d = cnt_q;
    ff_d = ff_q;
    irq_d = 1'b0;
    duty_d = duty_q;
    pend_d = pend_q;
    if (wr && PADDR == DUTY_HIGH_OFS)
    begin
      if (run)
        pend_d = 1'b1; // RL8
      else
        duty_d = {PWDATA[7:0], buf_low_q}; // RL9
    end
    if (run && tick)
    begin
      // one 16-bit counter, not two chained bytes with a carry delay
      cnt_d = ovf ? 16'h0000 : cnt_q + 16'h0001; // RL1 RL4 RL19
      ff_d = ff_q ^ match ^ ovf; // RL3 RL4
      if (ovf)
      begin
        irq_d = 1'b1; // RL4
        // a high-byte write in this very cycle joins the transfer with its new byte
        if (pend_q | pend_d)
        begin
          duty_d = {buf_high_d, buf_low_d}; // RL8
          pend_d = 1'b0;
        end
      end
    end
    // stopped writes reload the flip-flop, but not the stopping write
    if (wr && PADDR == UPPER_CTRL_OFS && !run && !run_new)
      ff_d = upper_timer_ctrl_d[INIT_BIT]; // RL6 RL14 RL15
    if (wr && PADDR == UPPER_CTRL_OFS && !run && run_new)
    begin
      ff_d = upper_timer_ctrl_d[INIT_BIT]; // RL6 RL18
      cnt_d = 16'h0000;
    end
    out_n_d = ~ff_d; // RL7
  end

  // ce low acts as a halted clock, so the pin cannot glitch
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pre_q <= '0;
      lowdiv_q <= '0;
      low_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      cnt_q <= 16'h0000;
      ff_q <= 1'b0; // RL6
      out_n_q <= 1'b1; // RL7
      irq_q <= 1'b0;
      duty_q <= DUTY_RST;
      pend_q <= 1'b0;
    end
    else if (CE) // RL16
    begin
      pre_q <= pre_d;
      lowdiv_q <= lowdiv_d;
      low_prev_q <= low_prev_d;
      ext_prev_q <= ext_prev_d;
      cnt_q <= cnt_d;
      ff_q <= ff_d;
      out_n_q <= out_n_d;
      irq_q <= irq_d;
      duty_q <= duty_d;
      pend_q <= pend_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = slverr_q;
  assign PWM_OUT_N = out_n_q;
  assign PERIOD_IRQ = irq_q;

  // checks
  pin_inverse_a: assert property (@(posedge CLK) disable iff (RST) // RL7
    PWM_OUT_N == ~ff_q)
    else $error("pwm pin not inverse of flip-flop");
  match_toggle_a: assert property (@(posedge CLK) disable iff (RST) // RL3
    CE && run && tick && match && !ovf && !wr |=>
      ff_q != $past(ff_q) && cnt_q == $past(cnt_q) + 16'h0001)
    else $error("duty match did not toggle");
  ovf_clear_a: assert property (@(posedge CLK) disable iff (RST) // RL4
    CE && run && tick && ovf && !wr |=> cnt_q == 16'h0000 && PERIOD_IRQ)
    else $error("overflow did not clear and signal");
  irq_cause_a: assert property (@(posedge CLK) disable iff (RST) // RL4
    PERIOD_IRQ |-> $past(ovf) && $past(run))
    else $error("period irq without overflow");
  stop_hold_a: assert property (@(posedge CLK) disable iff (RST) // RL14
    CE && !run && !wr |=> ff_q == $past(ff_q) && cnt_q == $past(cnt_q))
    else $error("stopped counter moved");
  stopped_load_a: assert property (@(posedge CLK) disable iff (RST) // RL9
    CE && !run && wr && PADDR == DUTY_HIGH_OFS |=>
      duty_q == {$past(PWDATA[7:0]), $past(buf_low_q)})
    else $error("stopped duty not loaded");
  run_buffer_a: assert property (@(posedge CLK) disable iff (RST) // RL8
    CE && run && !(tick && ovf) |=> duty_q == $past(duty_q))
    else $error("running duty changed off period");
  init_load_a: assert property (@(posedge CLK) disable iff (RST) // RL15
    CE && !run && wr && PADDR == UPPER_CTRL_OFS && !PWDATA[START_BIT]
      |=> ##1 PWM_OUT_N == ~$past(PWDATA[INIT_BIT], 2))
    else $error("init bit not on pin");
  apb_wait_a: assert property (@(posedge CLK) disable iff (RST)
    CE && PSEL && !PENABLE ##1 CE && PSEL && PENABLE |=> PREADY)
    else $error("apb answer late");
  irq_pulse_a: assert property (@(posedge CLK) disable iff (RST) // RL4
    CE && PERIOD_IRQ |=> !PERIOD_IRQ)
    else $error("period irq longer than one cycle");
  start_load_a: assert property (@(posedge CLK) disable iff (RST) // RL18
    CE && !run && wr && PADDR == UPPER_CTRL_OFS && PWDATA[START_BIT]
      |=> ff_q == $past(PWDATA[INIT_BIT]) && cnt_q == 16'h0000)
    else $error("start did not load flip-flop and clear count");
  stop_keep_a: assert property (@(posedge CLK) disable iff (RST) // RL14
    CE && run && !tick && wr && PADDR == UPPER_CTRL_OFS &&
      !PWDATA[START_BIT] |=> ff_q == $past(ff_q))
    else $error("stop write moved the flip-flop");
  run_count_a: assert property (@(posedge CLK) disable iff (RST) // RL1
    CE && run && tick && !ovf && !wr |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not advance on tick");
  slow_hold_a: assert property (@(posedge CLK) disable iff (RST) // RL17
    CE && run && sys_cfg_q[SLOW_BIT] && (sel == SRC_HIGH || sel == SRC_HALF)
      && !wr |=> cnt_q == $past(cnt_q))
    else $error("slow mode let a high-clock source count");
  pend_set_a: assert property (@(posedge CLK) disable iff (RST) // RL8
    CE && run && wr && PADDR == DUTY_HIGH_OFS && !(tick && ovf) |=> pend_q)
    else $error("running high write not held for period");
  duty_transfer_a: assert property (@(posedge CLK) disable iff (RST) // RL8
    CE && run && tick && ovf && pend_q && !wr
      |=> duty_q == {$past(buf_high_q), $past(buf_low_q)})
    else $error("buffered duty not moved at period end");
  ext_edge_a: assert property (@(posedge CLK) disable iff (RST) // RL2
    CE && run && sel == SRC_EXT && !COUNT_IN && ext_prev_q && !ovf && !wr
      |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("external falling edge not counted");
  unmapped_err_a: assert property (@(posedge CLK) disable iff (RST)
    CE && PSEL && PENABLE && !PREADY && !hit |=> PSLVERR && PREADY)
    else $error("unmapped address not refused");
endmodule : pwm16_gen
`default_nettype wire

// *** pwm16_partner.sv ***
// external count source model for the pwm generator
`timescale 1ns/1ps
`default_nettype none
module pwm16_partner
(
  // clock and enable
  input wire logic clk,
  input wire logic en,
  // count pin and edges sent
  output logic count_in,
  output int falls
);
  int ph = 0;
  int cnt = 0;
  assign falls = cnt;
  // each level held two cycles, idle high so no stray edge
  always @(posedge clk)
  begin
    ph <= en ? ph + 1 : 0;
    count_in <= en ? ~ph[1] : 1'b1;
    if (en && ph[1:0] == 2'd2)
      cnt <= cnt + 1;
  end
endmodule : pwm16_partner
`default_nettype wire

// *** cascaded_16bit_pwm_generator_test.sv ***
// self-checking bench for the cascaded pwm generator
`timescale 1ns/1ps
`default_nettype none
module cascaded_16bit_pwm_generator_test;
  import pwm16_pkg::*;
  typedef struct packed
  {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic e;
    logic p;
  } row_t;
  // address, write data, read back, error, pin
  row_t rows [8] = '{
    '{8'h00, 32'h60, 32'h60, 1'b0, 1'b1},
    '{8'h14, 32'h01, 32'h01, 1'b0, 1'b1},
    '{8'h14, 32'h00, 32'h00, 1'b0, 1'b1},
    '{8'h04, 32'h80, 32'h80, 1'b0, 1'b0},
    '{8'h04, 32'h00, 32'h00, 1'b0, 1'b1},
    '{8'h18, 32'hAB, 32'h00, 1'b1, 1'b1},
    '{8'h08, 32'h10, 32'h00, 1'b0, 1'b1},
    '{8'h0C, 32'h00, 32'h00, 1'b0, 1'b1}};
  logic CLK = 1'b0, RST = 1'b1, CE = 1'b1, LOW_CLK = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, ext_en = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, COUNT_IN, PWM_OUT_N, PERIOD_IRQ, er;
  int fails = 0, checks_done = 0, cyc = 0, falls, t0;
  // cycles per tick for source codes 0 to 5, then low clock over 8
  int divs [7] = '{2**DIV_A, 2**DIV_B, 2**DIV_C, 2**DIV_D, 8, 2,
    8 * 2**LOW_DIV};
  pwm16_gen uut
  (
    .CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .LOW_CLK(LOW_CLK),
    .COUNT_IN(COUNT_IN), .PWM_OUT_N(PWM_OUT_N), .PERIOD_IRQ(PERIOD_IRQ)
  );
  pwm16_partner src
  (
    .clk(CLK), .en(ext_en), .count_in(COUNT_IN), .falls(falls)
  );
  // 50 ns clock
  initial
  begin
    forever #25 CLK = ~CLK;
  end
  // cycle count, slow clock, and a ceiling well past one period
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    LOW_CLK <= cyc[2];
    if (cyc == 90000)
    begin
      fails++;
      results;
    end
  end
  task automatic results;
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  // one apb transfer; idles a cycle first so no signal moves twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    cmp("pready", 32'h1, PREADY);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  // bounded wait for pin or period pulse to reach a level
  task automatic hold(input logic irq, input logic v);
    int n;
    n = 0;
    while ((irq ? PERIOD_IRQ : PWM_OUT_N) !== v && n < 70000)
    begin
      @(posedge CLK);
      n++;
    end
  endtask : hold
  // main sequence
  initial
  begin
    repeat (12) @(posedge CLK);
    cmp("rst_out", 32'h1, {PERIOD_IRQ, PREADY, PWM_OUT_N});
    cmp("rst_rd", 32'h0, PRDATA);
    RST <= 1'b0;
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      cmp("reg", rows[i].r, rd);
      cmp("err_pin", {rows[i].e, rows[i].p}, {er, PWM_OUT_N});
    end
    apb(1'b0, DUTY_LOW_OFS, 32'h0);
    cmp("duty_stop", 32'h10, rd);
    apb(1'b1, SYS_CFG_OFS, 32'h2);
    apb(1'b1, UPPER_CTRL_OFS, 32'h8);
    repeat (20) @(posedge CLK);
    apb(1'b0, STATUS_OFS, 32'h0);
    cmp("slow_stat", 32'h10000, rd);
    apb(1'b1, UPPER_CTRL_OFS, 32'h0);
    apb(1'b1, SYS_CFG_OFS, 32'h0);
    apb(1'b1, UPPER_CTRL_OFS, 32'h8);
    hold(1'b0, 1'b0);
    t0 = cyc;
    cmp("start_pin", 32'h0, PWM_OUT_N);
    // written well clear of the period event
    apb(1'b1, DUTY_LOW_OFS, 32'h20);
    apb(1'b1, DUTY_HIGH_OFS, 32'h0);
    apb(1'b0, DUTY_LOW_OFS, 32'h0);
    cmp("duty_run", 32'h10, rd);
    apb(1'b0, STATUS_OFS, 32'h0);
    cmp("run_ff", 32'h3, rd[17:16]);
    cmp("no_clear", 32'h1, rd[15:0] > 16'h0010);
    hold(1'b1, 1'b1);
    cmp("match_irq", 65519, cyc - t0);
    cmp("irq_pin", 32'h1, PWM_OUT_N);
    t0 = cyc;
    hold(1'b0, 1'b0);
    cmp("new_duty", 33, cyc - t0);
    apb(1'b0, DUTY_LOW_OFS, 32'h0);
    cmp("duty_new", 32'h20, rd);
    apb(1'b1, UPPER_CTRL_OFS, 32'h0);
    repeat (5) @(posedge CLK);
    cmp("stop_hold", 32'h0, PWM_OUT_N);
    // reset after the stop, with the pin held low
    RST <= 1'b1;
    @(posedge CLK);
    cmp("rst2", 32'h1, {PERIOD_IRQ, PWM_OUT_N});
    RST <= 1'b0;
    apb(1'b0, STATUS_OFS, 32'h0);
    cmp("rst2_stat", 32'h0, rd);
    apb(1'b1, LOWER_CTRL_OFS, 32'h70);
    apb(1'b1, UPPER_CTRL_OFS, 32'h8);
    ext_en <= 1'b1;
    repeat (40) @(posedge CLK);
    ext_en <= 1'b0;
    repeat (6) @(posedge CLK);
    apb(1'b0, STATUS_OFS, 32'h0);
    cmp("ext_cnt", falls, rd[15:0]);
    // ce low freezes the counter although edges keep coming
    t0 = falls;
    CE <= 1'b0;
    ext_en <= 1'b1;
    repeat (20) @(posedge CLK);
    ext_en <= 1'b0;
    repeat (4) @(posedge CLK);
    CE <= 1'b1;
    apb(1'b0, STATUS_OFS, 32'h0);
    cmp("ce_freeze", t0, rd[15:0]);
    apb(1'b1, UPPER_CTRL_OFS, 32'h0);
    // every internal source but the high clock: four ticks in four of its periods
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, SYS_CFG_OFS, (i == 6) ? 32'h1 : 32'h0);
      apb(1'b1, LOWER_CTRL_OFS, (i == 6) ? 32'h0 : (32'(i) << SEL_LSB));
      apb(1'b1, UPPER_CTRL_OFS, 32'h8);
      repeat (4 * divs[i] - 2) @(posedge CLK);
      apb(1'b0, STATUS_OFS, 32'h0);
      cmp("src_rate", 32'h4, rd[15:0]);
      apb(1'b1, UPPER_CTRL_OFS, 32'h0);
    end
    results;
  end
endmodule : cascaded_16bit_pwm_generator_test
`default_nettype wire
